/* File: logic/adc_auto_sampling_sequencer.sv */
// Converter clock divider, SAR control, two sample sequencers and front-end link
//
// What this block does
// R1: 10-bit SAR result, one microsecond per conversion; here ten converter ticks, so one microsecond only with the divider at one
// R2: Converter clock divided from system, one to eight
// R3: Select two pins, amplifier, front-end voltages
// R4: Single or continuously repeating conversion mode
// R5: Conversion-finished event raised to processor
// R6: Two sequencers sample without processor help
// R7: Up to eight samples stored per sequencer
// R8: Each slot drives converter and front-end selection
// R9: Sequencer times the front-end sample-and-hold
// R10: Any of four timers starts a sequence
// R11: Chosen PWM rising or falling edge starts
// R12: Software can start a sequence directly
// R13: Ping-pong: finished sequencer starts the other
// R14: Sequence completion raised to processor
// R15: Front-end selection by sequencer or direct write
// R16: Hold asserted and released for back-to-back conversions
// R17: Eight converter channels, channel zero from front end
// R18: Front-end selector picks one of eight sources
// R19: Converter channels two and three are pins
// R20: Slot n result lands in result n
// R21: Sequencer zero wins simultaneous converter requests
`timescale 1ns/1ns
`include "adc_seq_regs.svh"
module adc_auto_sampling_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic [`DIV_W-1:0]         div_sel,
  input  wire logic                      man_start,
  input  wire logic                      man_repeat,
  input  wire chan_t                     man_chan,
  input  wire chan_t                     man_fe_sel,
  input  wire logic                      fe_direct_wr,
  input  wire chan_t                     fe_direct_sel,
  input  wire seq_cfg_t [1:0]            seq_cfg,
  input  wire logic [1:0]                seq_start,
  input  wire logic [`N_TIMERS-1:0]      timer_evt,
  input  wire logic [`N_TIMERS-1:0]      pwm_out,
  input  wire logic                      comp_ge,
  output logic                           conv_busy,
  output chan_t                          converter_input_selector,
  output chan_t                          frontend_selector,
  output logic                           frontend_hold,
  output sample_t                        dac_code,
  output sample_t                        man_result,
  output logic                           conv_done,
  output logic [1:0][`SLOTS-1:0][`RES_BITS-1:0] seq_result,
  output logic [1:0]                     seq_busy,
  output logic [1:0]                     seq_done
);

  state_t  st;
  state_t  next_st;
  logic    tick;
  logic    gsel;
  logic    own_k;
  logic    fin;
  logic [2:0] cur_slot;
  sample_t bit_mask;
  sample_t res_val;

  // Start decode for one sequencer: software, timer event or PWM edge
  function automatic logic start_hit(input seq_cfg_t c, input logic sw,
                                     input logic [`N_TIMERS-1:0] tev,
                                     input logic [`N_TIMERS-1:0] cur,
                                     input logic [`N_TIMERS-1:0] prev);
    logic t;
    logic r;
    logic f;
    t = (c.src == TRIG_TIMER) && tev[c.timer_idx];
    r = (c.src == TRIG_PWM_RISE) && cur[c.timer_idx] && !prev[c.timer_idx];
    f = (c.src == TRIG_PWM_FALL) && !cur[c.timer_idx] && prev[c.timer_idx];
    return sw | t | r | f;
  endfunction : start_hit

  // Converter clock as a tick; >= keeps it safe when the ratio shrinks
  assign tick     = (st.div_cnt >= div_sel);                 // [R2]
  assign gsel     = !st.run[0];                              // [R21]
  assign own_k    = (st.owner == OWN_SEQ1);
  assign cur_slot = st.slot[own_k];
  assign fin      = (st.fsm == CV_CONVERT) && tick && (st.bit_idx == 4'h0);
  // SAR trial: keep the bit when the comparator says input is above
  assign bit_mask = sample_t'(10'h001 << st.bit_idx);
  assign res_val  = comp_ge ? st.sar : (st.sar & ~bit_mask); // [R1]

  // Next-state logic for converter, sequencers and front-end link
  always_comb begin
    next_st           = st;
    next_st.conv_done = 1'b0;
    next_st.seq_done  = 2'b00;
    next_st.pwm_prev  = pwm_out;
    next_st.div_cnt   = tick ? '0 : st.div_cnt + 3'h1;
    unique case (st.fsm)
      CV_IDLE: begin
        if (st.run != 2'b00) begin
          // Sequencer zero first; the other waits until sequencer zero's whole run has ended
          next_st.owner     = gsel ? OWN_SEQ1 : OWN_SEQ0;             // [R21]
          next_st.conv_chan = seq_cfg[gsel].chan[st.slot[gsel]];      // [R8] [R17]
          next_st.fe_sel    = seq_cfg[gsel].fe[st.slot[gsel]];        // [R8] [R15] [R18]
          next_st.fsm       = CV_SAMPLE;                              // [R6]
          next_st.fe_hold   = 1'b0;
          next_st.sh_cnt    = 4'(`SAMPLE_TICKS - 1);
        end else if (st.man_pend) begin
          next_st.owner     = OWN_MAN;
          next_st.man_pend  = 1'b0;
          next_st.conv_chan = man_chan;                               // [R3] [R19]
          next_st.fe_sel    = man_fe_sel;
          next_st.fsm       = CV_SAMPLE;
          next_st.fe_hold   = 1'b0;
          next_st.sh_cnt    = 4'(`SAMPLE_TICKS - 1);
        end else if (fe_direct_wr) begin
          next_st.fe_sel    = fe_direct_sel;                          // [R15]
        end
      end
      CV_SAMPLE: begin
        // Track phase, then freeze the front end for the conversion
        if (tick) begin
          if (st.sh_cnt == 4'h0) begin
            next_st.fsm     = CV_CONVERT;
            next_st.fe_hold = 1'b1;                                   // [R9] [R16]
            next_st.sar     = sample_t'(1) << (`RES_BITS - 1);
            next_st.bit_idx = 4'(`RES_BITS - 1);
          end else begin
            next_st.sh_cnt  = st.sh_cnt - 4'h1;
          end
        end
      end
      CV_CONVERT: begin
        if (tick && st.bit_idx != 4'h0) begin
          next_st.sar     = res_val | (bit_mask >> 1);                // [R1]
          next_st.bit_idx = st.bit_idx - 4'h1;
        end else if (fin) begin
          // Release hold at once so the next slot can start tracking
          next_st.fsm       = CV_IDLE;
          next_st.fe_hold   = 1'b0;                                   // [R16]
          next_st.conv_done = 1'b1;                                   // [R5]
          if (st.owner == OWN_MAN) begin
            next_st.man_result = res_val;
            if (man_repeat) begin
              next_st.man_pend = 1'b1;                                // [R4]
            end
          end else begin
            next_st.seq_result[own_k][cur_slot] = res_val;            // [R7] [R20]
            if (cur_slot == seq_cfg[own_k].len_m1) begin
              next_st.run[own_k]      = 1'b0;
              next_st.slot[own_k]     = 3'h0;
              next_st.seq_done[own_k] = 1'b1;                         // [R14]
              if (seq_cfg[own_k].pingpong && !st.run[!own_k]) begin
                next_st.run[!own_k]  = 1'b1;                          // [R13]
                next_st.slot[!own_k] = 3'h0;
              end
            end else begin
              next_st.slot[own_k] = cur_slot + 3'h1;                  // [R20]
            end
          end
        end
      end
      default: begin
        next_st.fsm = CV_IDLE;
      end
    endcase
    // Starts after completion, so a start in the finishing cycle restarts
    for (int k = 0; k < 2; k++) begin
      if (!next_st.run[k] && start_hit(seq_cfg[k], seq_start[k], timer_evt,
                                       pwm_out, st.pwm_prev)) begin
        next_st.run[k]  = 1'b1;                                       // [R10] [R11] [R12]
        next_st.slot[k] = 3'h0;
      end
    end
    if (man_start) begin
      next_st.man_pend = 1'b1;                                        // [R4]
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st       <= '0;
      st.fsm   <= CV_IDLE;
      st.owner <= OWN_MAN;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign conv_busy                = (st.fsm != CV_IDLE);
  assign converter_input_selector = st.conv_chan;
  assign frontend_selector        = st.fe_sel;
  assign frontend_hold            = st.fe_hold;
  assign dac_code                 = st.sar;
  assign man_result               = st.man_result;
  assign conv_done                = st.conv_done;
  assign seq_result               = st.seq_result;
  assign seq_busy                 = st.run;
  assign seq_done                 = st.seq_done;

  // Divider at one ticks every cycle
  a_div_one: assert property (@(posedge core_clk) disable iff (srst) // [R2]
    (div_sel == 3'h0) |-> tick)
    else $error("divider /1 missed a tick");

  // Divider at eight leaves seven quiet cycles
  a_div_eight: assert property (@(posedge core_clk) disable iff (srst) // [R2]
    (tick && div_sel == 3'h7) |=> !tick [*7] ##1 tick)
    else $error("divider /8 spacing wrong");

  // Ten bit decisions per conversion at full rate
  a_conv_bits: assert property (@(posedge core_clk) disable iff (srst) // [R1]
    ($rose(st.fsm == CV_CONVERT) && div_sel == 3'h0) |->
      (st.fsm == CV_CONVERT) [*8] ##1 (st.fsm == CV_CONVERT) [*2] ##1 (st.fsm == CV_IDLE))
    else $error("conversion length wrong");

  // Hold exactly while converting
  a_hold_conv: assert property (@(posedge core_clk) disable iff (srst) // [R9] [R16]
    st.fe_hold == (st.fsm == CV_CONVERT))
    else $error("front-end hold out of step");

  // Simultaneous requests go to sequencer zero
  a_seq_priority: assert property (@(posedge core_clk) disable iff (srst) // [R21]
    (st.fsm == CV_IDLE && st.run == 2'b11) |=> (st.owner == OWN_SEQ0 && st.fsm == CV_SAMPLE))
    else $error("sequencer zero not granted first");

  // Finished sequencer zero starts sequencer one in ping-pong
  a_ping_pong: assert property (@(posedge core_clk) disable iff (srst) // [R13]
    (fin && st.owner == OWN_SEQ0 && st.slot[0] == seq_cfg[0].len_m1 && seq_cfg[0].pingpong)
      |=> (st.run[1] && st.seq_done[0]))
    else $error("ping-pong start missing");

  // Result stored in the slot it was taken for
  a_slot_store: assert property (@(posedge core_clk) disable iff (srst) // [R7] [R20]
    (fin && st.owner != OWN_MAN) |=>
      (st.seq_result[$past(own_k)][$past(cur_slot)] == $past(res_val)))
    else $error("sequence result in wrong slot");

  // Done is a single pulse with hold released
  a_done_pulse: assert property (@(posedge core_clk) disable iff (srst) // [R5]
    fin |=> (st.conv_done && !st.fe_hold) ##1 !st.conv_done)
    else $error("conversion done pulse wrong");

  // Single mode does not queue another conversion
  a_man_single: assert property (@(posedge core_clk) disable iff (srst) // [R4]
    (fin && st.owner == OWN_MAN && !man_repeat && !man_start && !st.man_pend)
      |=> !st.man_pend)
    else $error("single conversion repeated");

  // Slot routing reaches both selectors on grant
  a_slot_route: assert property (@(posedge core_clk) disable iff (srst) // [R8]
    (st.fsm == CV_IDLE && st.run[0]) |=>
      (st.conv_chan == $past(seq_cfg[0].chan[st.slot[0]])
       && st.fe_sel == $past(seq_cfg[0].fe[st.slot[0]])))
    else $error("slot selection not driven");

  // Tracking lasts two converter ticks at full rate
  a_sample_len: assert property (@(posedge core_clk) disable iff (srst) // [R9]
    ($rose(st.fsm == CV_SAMPLE) && div_sel == 3'h0) |->
      (st.fsm == CV_SAMPLE) [*2] ##1 (st.fsm == CV_CONVERT))
    else $error("sample phase length wrong");

  // Conversion opens with the top bit as trial
  a_sar_start: assert property (@(posedge core_clk) disable iff (srst) // [R1]
    $rose(st.fsm == CV_CONVERT) |-> (st.sar == 10'h200 && st.bit_idx == 4'h9))
    else $error("SAR trial does not start at top bit");

  // Selections stay put while a conversion is in flight
  a_sel_steady: assert property (@(posedge core_clk) disable iff (srst) // [R8] [R15]
    (st.fsm != CV_IDLE) |=> ($stable(st.fe_sel) && $stable(st.conv_chan)))
    else $error("selection moved during conversion");

  // Direct write lands when the link is free
  a_direct_write: assert property (@(posedge core_clk) disable iff (srst) // [R15]
    (st.fsm == CV_IDLE && st.run == 2'b00 && !st.man_pend && fe_direct_wr) |=>
      (st.fe_sel == $past(fe_direct_sel)))
    else $error("direct front-end write lost");

  // Software start arms an idle sequencer at slot zero
  a_soft_start: assert property (@(posedge core_clk) disable iff (srst) // [R12]
    (!st.run[0] && seq_start[0]) |=> (st.run[0] && st.slot[0] == 3'h0))
    else $error("software start ignored");

  // Selected timer event starts sequencer one
  a_timer_start: assert property (@(posedge core_clk) disable iff (srst) // [R10]
    (!st.run[1] && seq_cfg[1].src == TRIG_TIMER && timer_evt[seq_cfg[1].timer_idx]) |=>
      st.run[1])
    else $error("timer start ignored");

  // Falling PWM edge starts sequencer zero when chosen
  a_pwm_edge: assert property (@(posedge core_clk) disable iff (srst) // [R11]
    (!st.run[0] && seq_cfg[0].src == TRIG_PWM_FALL && !pwm_out[seq_cfg[0].timer_idx]
     && st.pwm_prev[seq_cfg[0].timer_idx]) |=> st.run[0])
    else $error("PWM edge start ignored");

  // Last slot of sequencer one raises its done pulse
  a_seq1_done: assert property (@(posedge core_clk) disable iff (srst) // [R14]
    (fin && st.owner == OWN_SEQ1 && st.slot[1] == seq_cfg[1].len_m1) |=> st.seq_done[1])
    else $error("sequence done pulse missing");

  // Running slot never passes the programmed length
  a_slot_bound: assert property (@(posedge core_clk) disable iff (srst) // [R7]
    st.run[0] |-> (st.slot[0] <= seq_cfg[0].len_m1))
    else $error("slot index beyond sequence length");

  // Manual work waits while any sequencer wants the converter
  a_man_waits: assert property (@(posedge core_clk) disable iff (srst) // [R21]
    (st.fsm == CV_IDLE && st.run != 2'b00) |=> (st.owner != OWN_MAN))
    else $error("manual conversion beat a sequencer");

endmodule : adc_auto_sampling_sequencer

/* File: logic/adc_seq_pkg.sv */
// Types shared by the converter sequencer
`include "adc_seq_regs.svh"
package adc_seq_pkg;
  typedef enum logic [1:0] {CV_IDLE, CV_SAMPLE, CV_CONVERT} conv_fsm_t;
  typedef enum logic [1:0] {OWN_MAN, OWN_SEQ0, OWN_SEQ1} owner_t;
  typedef enum logic [1:0] {TRIG_TIMER, TRIG_PWM_RISE, TRIG_PWM_FALL, TRIG_NONE} trig_t;
  typedef logic [`RES_BITS-1:0] sample_t;
  typedef logic [`CHAN_W-1:0]   chan_t;
  typedef struct packed {
    logic [2:0]              len_m1;    // Samples per sequence minus one
    trig_t                   src;
    logic [1:0]              timer_idx;
    logic                    pingpong;
    logic [`SLOTS-1:0][2:0]  chan;      // Converter input per slot
    logic [`SLOTS-1:0][2:0]  fe;        // Front-end input per slot
  } seq_cfg_t;
  typedef struct packed {
    conv_fsm_t                        fsm;
    owner_t                           owner;
    logic [`DIV_W-1:0]                div_cnt;
    logic [3:0]                       sh_cnt;
    logic [3:0]                       bit_idx;
    sample_t                          sar;
    chan_t                            conv_chan;
    chan_t                            fe_sel;
    logic                             fe_hold;
    logic [1:0]                       run;
    logic [1:0][2:0]                  slot;
    logic                             man_pend;
    logic [`N_TIMERS-1:0]             pwm_prev;
    sample_t                          man_result;
    logic [1:0][`SLOTS-1:0][`RES_BITS-1:0] seq_result;
    logic                             conv_done;
    logic [1:0]                       seq_done;
  } state_t;
endpackage : adc_seq_pkg

/* File: logic/adc_seq_regs.svh */
// Timing counts, widths and fixed channel numbers of the converter sequencer
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
`define RES_BITS      10
`define SLOTS         8
`define CHAN_W        3
`define DIV_W         3
`define N_TIMERS      4
`define CLK_MHZ       10
`define SAMPLE_NS     200
`define SAMPLE_TICKS  ((`SAMPLE_NS * `CLK_MHZ + 999) / 1000)
`define CONV_NS       1000
`define CONV_TICKS    (`CONV_NS * `CLK_MHZ / 1000)
`define CH_FRONTEND   3'h0
`define CH_PIN_TWO    3'h2
`define CH_PIN_THREE  3'h3
`endif

/* File: tb/afe_model.sv */
// Analog front end and comparator facing the converter
`timescale 1ns/1ns
`include "adc_seq_regs.svh"
module afe_model
  import adc_seq_pkg::*;
(
  input  wire logic    core_clk,
  input  wire chan_t   converter_input_selector,
  input  wire chan_t   frontend_selector,
  input  wire logic    frontend_hold,
  input  wire sample_t dac_code,
  output logic         comp_ge
);
  sample_t held;
  logic    flip = 1'b0;
  // Level per input; channel zero carries the front-end source
  function automatic sample_t level(input chan_t ch, input chan_t fe);
    return (ch == 3'h0) ? {3'h0, fe, 4'ha} : {ch, 3'h5, 4'h3};
  endfunction : level
  // Track while open, freeze while held
  always @(posedge core_clk) begin
    flip <= !flip;
    if (!frontend_hold) held <= level(converter_input_selector, frontend_selector);
  end
  // Outside hold the answer toggles, so a decision taken too early shows up
  assign comp_ge = frontend_hold ? (held >= dac_code) : flip;
endmodule : afe_model

/* File: tb/tb_adc_auto_sampling_sequencer.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`include "adc_seq_regs.svh"
module tb_adc_auto_sampling_sequencer
  import adc_seq_pkg::*;
;
  logic                 core_clk = 1'b0;
  logic                 srst = 1'b1;
  logic [`DIV_W-1:0]    div_sel = '0;
  logic                 man_start = 1'b0;
  logic                 man_repeat = 1'b0;
  chan_t                man_chan = '0;
  chan_t                man_fe_sel = '0;
  logic                 fe_direct_wr = 1'b0;
  chan_t                fe_direct_sel = '0;
  seq_cfg_t [1:0]       seq_cfg = '0;
  logic [1:0]           seq_start = '0;
  logic [`N_TIMERS-1:0] timer_evt = '0;
  logic [`N_TIMERS-1:0] pwm_out = '0;
  logic                 comp_ge, conv_busy, frontend_hold, conv_done;
  chan_t                converter_input_selector, frontend_selector;
  sample_t              dac_code, man_result;
  logic [1:0]           seq_busy, seq_done;
  logic [1:0][`SLOTS-1:0][`RES_BITS-1:0] seq_result;
  int                   n_fail = 0;
  int                   n_checks = 0;
  int                   seed = 32'hc43761db;
  sample_t              man_q[$];
  seq_cfg_t             sq[2][$];

  adc_auto_sampling_sequencer adc_auto_sampling_sequencer_i (.core_clk, .srst, .div_sel,
    .man_start, .man_repeat, .man_chan, .man_fe_sel, .fe_direct_wr, .fe_direct_sel, .seq_cfg,
    .seq_start, .timer_evt, .pwm_out, .comp_ge, .conv_busy, .converter_input_selector,
    .frontend_selector, .frontend_hold, .dac_code, .man_result, .conv_done, .seq_result,
    .seq_busy, .seq_done);
  afe_model afe_model_i (.core_clk, .converter_input_selector, .frontend_selector,
    .frontend_hold, .dac_code, .comp_ge);

  // Same input levels as the front-end model, worked out independently
  function automatic sample_t level(input chan_t ch, input chan_t fe);
    return (ch == 3'h0) ? {3'h0, fe, 4'ha} : {ch, 3'h5, 4'h3};
  endfunction : level

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic wait_quiet();
    int i;
    #1;
    for (i = 0; i < 3000 && (conv_busy !== 1'b0 || seq_busy !== 2'b00); i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 3000) begin
      n_fail++;
      final_report();
    end
  endtask : wait_quiet

  // One manual conversion; latency and hold length measured from the sampling edge
  task automatic manual(input int ch, input int fe, input int d);
    int n;
    int h;
    @(posedge core_clk);
    // Ratio changes under reset, so no divider window straddles the change
    div_sel <= d[2:0];
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    repeat (8) @(posedge core_clk);
    man_chan <= ch[2:0];
    man_fe_sel <= fe[2:0];
    man_start <= 1'b1;
    man_q.push_back(level(ch[2:0], fe[2:0]));
    @(posedge core_clk);
    man_start <= 1'b0;
    h = 0;
    for (n = 1; n < 600; n++) begin
      @(posedge core_clk);
      #1;
      h += int'(frontend_hold);
      if (conv_done === 1'b1) break;
    end
    if (n == 600) begin
      n_fail++;
      final_report();
    end
    // One grant cycle, then two sample and ten convert ticks
    if (d == 0) check(n, 13);
    if (d == 0) check(h, 10);
    check(n >= 11 * (d + 1) + 2 && n <= 12 * (d + 1) + 1, 1'b1);
    if (!man_repeat) begin
      repeat (20) @(posedge core_clk);
      #1 check(conv_busy, 1'b0);
    end
  endtask : manual

  // Random slot programme for one sequencer, noted before it can run
  task automatic arm(input int k, input trig_t src, input logic pp, input logic full);
    seq_cfg_t c;
    c = $bits(seq_cfg_t)'({$random(seed), $random(seed)});
    c.src = src;
    c.pingpong = pp;
    if (full) c.len_m1 = 3'h7;
    @(posedge core_clk);
    seq_cfg[k] <= c;
    sq[k].push_back(c);
  endtask : arm

  task automatic pulse(input logic [1:0] s, input logic [3:0] t);
    @(posedge core_clk);
    seq_start <= s;
    timer_evt <= t;
    @(posedge core_clk);
    seq_start <= 2'b00;
    timer_evt <= 4'h0;
  endtask : pulse

  task automatic see(input int k, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      @(posedge core_clk);
      #1;
      if (seq_busy[k] === 1'b1) seen = 1'b1;
    end
    check(seen, exp);
  endtask : see

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // Scoreboard: each finished result takes the oldest note
  always @(posedge core_clk) begin
    seq_cfg_t c;
    #1;
    if (conv_done === 1'b1) check(frontend_hold, 1'b0);
    if (conv_done === 1'b1 && seq_busy === 2'b00 && seq_done === 2'b00 && man_q.size() > 0)
      check(man_result, man_q.pop_front());
    for (int k = 0; k < 2; k++)
      if (seq_done[k] === 1'b1 && sq[k].size() > 0) begin
        c = sq[k].pop_front();
        for (int n = 0; n <= c.len_m1; n++)
          check(seq_result[k][n], level(c.chan[n], c.fe[n]));
      end
  end

  initial begin
    #8000000;
    n_fail++;
    final_report();
  end

  initial begin
    int i;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    fe_direct_sel <= 3'h6;
    fe_direct_wr <= 1'b1;
    @(posedge core_clk);
    fe_direct_wr <= 1'b0;
    #1 check(frontend_selector, 3'h6);
    // Channel i at divider setting i, then every front-end source on channel zero
    for (i = 0; i < 16; i++) manual(i < 8 ? i : 0, i, i < 8 ? i : 0);
    // Repeating mode must keep converting without new starts
    @(posedge core_clk);
    man_repeat <= 1'b1;
    man_q.push_back(level(3'h3, 3'h0));
    man_q.push_back(level(3'h3, 3'h0));
    manual(3, 0, 0);
    for (i = 0; i < 200 && man_q.size() > 0; i++) @(posedge core_clk);
    check(man_q.size(), 0);
    if (i == 200) final_report();
    @(posedge core_clk);
    man_repeat <= 1'b0;
    wait_quiet();
    arm(0, TRIG_NONE, 1'b0, 1'b1);
    pulse(2'b01, 4'h0);
    see(0, 1'b1);
    wait_quiet();
    // Foreign timer ignored, own timer taken
    arm(1, TRIG_TIMER, 1'b0, 1'b0);
    pulse(2'b00, 4'h1 << ((sq[1][0].timer_idx + 1) % 4));
    see(1, 1'b0);
    pulse(2'b00, 4'h1 << sq[1][0].timer_idx);
    see(1, 1'b1);
    wait_quiet();
    // Opposite edge first, then the chosen edge
    for (i = 1; i < 3; i++) begin
      @(posedge core_clk);
      pwm_out <= {4{i == 1}};
      arm(0, trig_t'(i), 1'b0, 1'b0);
      repeat (2) @(posedge core_clk);
      pwm_out[sq[0][0].timer_idx] <= (i != 1);
      see(0, 1'b0);
      @(posedge core_clk);
      pwm_out[sq[0][0].timer_idx] <= (i == 1);
      see(0, 1'b1);
      wait_quiet();
    end
    arm(0, TRIG_NONE, 1'b1, 1'b0);
    arm(1, TRIG_NONE, 1'b0, 1'b0);
    pulse(2'b01, 4'h0);
    for (i = 0; i < 2000 && seq_done[0] !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 2000) begin
      n_fail++;
      final_report();
    end
    see(1, 1'b1);
    wait_quiet();
    // Both started together: sequencer zero takes the converter first
    arm(0, TRIG_NONE, 1'b0, 1'b0);
    arm(1, TRIG_NONE, 1'b0, 1'b0);
    pulse(2'b11, 4'h0);
    for (i = 0; i < 20 && conv_busy !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 20) begin
      n_fail++;
      final_report();
    end
    check(converter_input_selector, sq[0][0].chan[0]);
    check(frontend_selector, sq[0][0].fe[0]);
    wait_quiet();
    check(man_q.size() + sq[0].size() + sq[1].size(), 0);
    final_report();
  end
endmodule : tb_adc_auto_sampling_sequencer
